// ### src/fpol_loader.sv
// flash sector lock, frequency registers, command state and option loader
`timescale 1ns/1ps
module fpol_loader
  import fpol_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register file access
  input wire fpol_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  // debugger and power state
  input wire logic dbg_mode,
  input wire logic stop_recover,
  output logic cpu_hold,
  // flash option read port
  output logic flash_rd_req,
  output logic [15:0] flash_rd_addr,
  input wire logic flash_rd_valid,
  input wire logic [7:0] flash_rd_data,
  // program and erase permission
  input wire logic [6:0] prog_page,
  output logic prog_permit,
  // state seen by the flash controller
  output logic [7:0] sector_lock_mask,
  output logic [7:0] page_select_reg,
  output logic [15:0] flash_clock_khz,
  output logic [5:0] flash_state_reg,
  // loaded option configuration
  output fpol_opt_cfg_type opt_cfg
);

  fpol_cmd_state_type cmd_state_r;
  fpol_cmd_state_type cmd_state_nxt;
  logic [7:0] sector_lock_mask_r;
  logic [7:0] sector_lock_mask_nxt;
  logic [7:0] page_select_r;
  logic [7:0] khz_high_r;
  logic [7:0] khz_low_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [5:0] state_code_r;
  logic cpu_hold_r;
  logic prog_permit_r;
  fpol_opt_cfg_type opt_cfg_r;
  logic fetch_start;
  logic fetch_done;
  logic [7:0] fetch_byte;

  // address decode
  wire wr_cmd;
  wire wr_page_addr;
  wire wr_khz_hi;
  wire wr_khz_lo;
  wire protect_sel;
  wire wr_lock_mask;
  wire wr_page_sel;
  wire [2:0] prog_sector;
  wire sector_open;
  wire [7:0] cmd;
  wire addr_mapped;

  assign cmd = reg_req.wdata;
  assign addr_mapped = reg_req.addr inside {FPOL_ADDR_CMD, FPOL_ADDR_PAGE,
    FPOL_ADDR_KHZ_HI, FPOL_ADDR_KHZ_LO};
  assign wr_cmd = reg_req.wr && (reg_req.addr == FPOL_ADDR_CMD);
  assign wr_page_addr = reg_req.wr && (reg_req.addr == FPOL_ADDR_PAGE);
  assign wr_khz_hi = reg_req.wr && (reg_req.addr == FPOL_ADDR_KHZ_HI);
  assign wr_khz_lo = reg_req.wr && (reg_req.addr == FPOL_ADDR_KHZ_LO);
  assign protect_sel = (cmd_state_r == FC_PROTECT);
  assign wr_lock_mask = wr_page_addr && protect_sel;
  assign wr_page_sel = wr_page_addr && !protect_sel;
  assign prog_sector = prog_page[FPOL_SECT_HI:FPOL_SECT_LO];
  assign sector_open = !sector_lock_mask_r[prog_sector];

  // user code only sets bits; debugger writes both ways
  assign sector_lock_mask_nxt = dbg_mode ? reg_req.wdata
    : (sector_lock_mask_r | reg_req.wdata);

  // command sequencer; any unexpected command write relocks
  always_comb
  begin
    cmd_state_nxt = cmd_state_r;
    if (wr_cmd)
    begin
      cmd_state_nxt = FC_LOCKED;
      case (cmd_state_r)
        FC_LOCKED:
        begin
          if (cmd == FPOL_CMD_UNLOCK1)
          begin
            cmd_state_nxt = FC_FIRST;
          end
          else if (cmd == FPOL_CMD_SEL_PROTECT)
          begin
            cmd_state_nxt = FC_PROTECT;
          end
        end
        FC_FIRST:
        begin
          if (cmd == FPOL_CMD_UNLOCK2)
          begin
            cmd_state_nxt = FC_SECOND;
          end
        end
        default: cmd_state_nxt = FC_LOCKED;
      endcase
    end
    else if (wr_page_sel && (cmd_state_r == FC_SECOND))
    begin
      cmd_state_nxt = FC_UNLOCKED;
    end
    else if (wr_page_sel && dbg_mode && (cmd_state_r == FC_FIRST))
    begin
      cmd_state_nxt = FC_UNLOCKED;
    end
  end

  // read data mux; option configuration has no address
  always_comb
  begin
    rdata_nxt = FPOL_RST_BYTE;
    case (reg_req.addr)
      FPOL_ADDR_CMD: rdata_nxt = {2'b00, fpol_state_code(cmd_state_r)};
      FPOL_ADDR_PAGE: rdata_nxt = protect_sel ? sector_lock_mask_r : page_select_r;
      FPOL_ADDR_KHZ_HI: rdata_nxt = khz_high_r;
      FPOL_ADDR_KHZ_LO: rdata_nxt = khz_low_r;
      default: rdata_nxt = FPOL_RST_BYTE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cmd_state_r <= FC_LOCKED;
      state_code_r <= FPOL_ST_LOCKED;
    end
    else
    begin
      cmd_state_r <= cmd_state_nxt;
      state_code_r <= fpol_state_code(cmd_state_nxt);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sector_lock_mask_r <= FPOL_RST_BYTE;
      page_select_r <= FPOL_RST_BYTE;
    end
    else
    begin
      if (wr_lock_mask)
      begin
        sector_lock_mask_r <= sector_lock_mask_nxt;
      end
      if (wr_page_sel)
      begin
        page_select_r <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      khz_high_r <= FPOL_RST_BYTE;
      khz_low_r <= FPOL_RST_BYTE;
    end
    else
    begin
      if (wr_khz_hi)
      begin
        khz_high_r <= reg_req.wdata;
      end
      if (wr_khz_lo)
      begin
        khz_low_r <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rdata_r <= FPOL_RST_BYTE;
    end
    else if (reg_req.rd)
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // debugger ignores locks; user code needs write enable and open sector
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      prog_permit_r <= 1'b0;
    end
    else
    begin
      prog_permit_r <= dbg_mode || (opt_cfg_r.user_write_ok && sector_open);
    end
  end

  // option reload on stop recovery; reset starts the fetch on its own
  assign fetch_start = stop_recover;

  fpol_opt_fetch u_fetch (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(fetch_start),
    .done(fetch_done),
    .opt_byte(fetch_byte),
    .flash_rd_req(flash_rd_req),
    .flash_rd_addr(flash_rd_addr),
    .flash_rd_valid(flash_rd_valid),
    .flash_rd_data(flash_rd_data)
  );

  // cpu held until the option byte is in, except a stop recovery in the fetch_done cycle; config changes only on a load
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cpu_hold_r <= 1'b1;
      opt_cfg_r <= fpol_decode_opt(FPOL_OPT_ERASED);
    end
    else
    begin
      if (fetch_done)
      begin
        opt_cfg_r <= fpol_decode_opt(fetch_byte);
        cpu_hold_r <= 1'b0;
      end
      else if (stop_recover)
      begin
        cpu_hold_r <= 1'b1;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign cpu_hold = cpu_hold_r;
  assign prog_permit = prog_permit_r;
  assign sector_lock_mask = sector_lock_mask_r;
  assign page_select_reg = page_select_r;
  assign flash_clock_khz = {khz_high_r, khz_low_r};
  assign flash_state_reg = state_code_r;
  assign opt_cfg = opt_cfg_r;

  // checks
  AST_USER_SET_ONLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_lock_mask && !dbg_mode |=>
      sector_lock_mask_r == ($past(sector_lock_mask_r) | $past(reg_req.wdata)))
    else $error("user write cleared a sector lock bit");

  AST_DBG_WRITE_BOTH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_lock_mask && dbg_mode |=> sector_lock_mask_r == $past(reg_req.wdata))
    else $error("debugger write to sector lock mask not taken");

  AST_MASK_NEEDS_SELECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_page_addr && !protect_sel |=> $stable(sector_lock_mask_r))
    else $error("sector lock mask changed without select-protect");

  AST_PAGE_HIDDEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_page_addr && protect_sel |=> $stable(page_select_r))
    else $error("page select written while protect selected");

  AST_PROTECT_CODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr == FPOL_ADDR_CMD && protect_sel |=> reg_rdata == 8'h04)
    else $error("state code wrong while protect selected");

  AST_BAD_CMD_LOCKS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_cmd && cmd_state_r != FC_LOCKED && cmd == FPOL_CMD_SEL_PROTECT
      |=> cmd_state_r == FC_LOCKED ##0 flash_state_reg == FPOL_ST_LOCKED)
    else $error("out of order select-protect did not lock");

  AST_UNLOCK_SEQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_cmd && cmd_state_r == FC_FIRST && cmd == FPOL_CMD_UNLOCK2
      |=> flash_state_reg == FPOL_ST_SECOND)
    else $error("unlock sequence not followed");

  AST_KHZ_HIGH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_khz_hi |=> flash_clock_khz[15:8] == $past(reg_req.wdata))
    else $error("frequency high byte not in upper half");

  AST_HOLD_TILL_LOAD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(cpu_hold_r) |-> $past(fetch_done) && opt_cfg_r == fpol_decode_opt($past(fetch_byte)))
    else $error("cpu released without loaded options");

  AST_OPT_STABLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(fetch_done) |-> $stable(opt_cfg_r))
    else $error("option configuration changed outside a load");

  AST_STOP_RELOAD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stop_recover && !fetch_done |=> cpu_hold_r ##1 flash_rd_req)
    else $error("stop recovery did not reload options");

  AST_LOCK_BLOCKS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !dbg_mode && sector_lock_mask_r[prog_sector] |=> !prog_permit)
    else $error("locked sector permitted for program");

  AST_SELECT_PROTECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_cmd && cmd_state_r == FC_LOCKED && cmd == FPOL_CMD_SEL_PROTECT
      |=> flash_state_reg == FPOL_ST_PROTECT)
    else $error("select-protect command not taken");

  AST_PAGE_TAKEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_page_sel
      |=> page_select_reg == $past(reg_req.wdata))
    else $error("page select write lost");

  AST_KHZ_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_khz_lo
      |=> flash_clock_khz[7:0] == $past(reg_req.wdata))
    else $error("frequency low byte not in lower half");

  AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && !addr_mapped
      |=> reg_rdata == FPOL_RST_BYTE)
    else $error("unmapped read returned data");

  AST_RESET_FETCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(sys_rst)
      |-> cpu_hold_r ##1 flash_rd_req)
    else $error("reset release did not start an option fetch");

  AST_HOLD_WHILE_FETCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    flash_rd_req
      |-> cpu_hold_r)
    else $error("cpu running while options are fetched");

  AST_WRITE_LOCK_BLOCKS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !dbg_mode && !opt_cfg_r.user_write_ok
      |=> !prog_permit)
    else $error("write lock option did not block program");

endmodule // fpol_loader

// ### src/fpol_pkg.sv
// constants, types and helpers of the flash protect and option loader
// Operation
// - shared address reaches sector lock mask only after select-protect command
// - user code may set sector lock bits, never clear them
// - a set sector lock bit blocks user program and erase; reset zero
// - high and low frequency bytes form the 16-bit kHz value; reset zero
// - every reset, stop recovery included, reloads the option byte from flash
// - option byte changes act only after the next reset
// - option load completes before the CPU leaves reset; a stop recovery in the fetch_done cycle reloads with the CPU released
// - option configuration is never reachable by register reads or writes
// - options come from flash byte 0000H; 0001H stays unprogrammed
// - option bit 7 zero gives watchdog interrupt, one gives short reset
// - option bit 6 zero starts watchdog at power-up, one by instruction
// - option bits 5:4 select RC, low, medium or high power oscillator
// - option bit 3 zero drops brownout in stop, one keeps it always
// - option bit 2 zero locks code reads and limits the debugger; here debugger access ignores bit 2
// - option bit 0 zero blocks user program and erase of all flash
// - page select register unreachable while select-protect is in effect
// - flash state register reads 00 0100 while sector lock mask selected
// - debugger writes may set and clear sector lock bits
// - unknown or out-of-sequence commands lock the flash controller
package fpol_pkg;

  // register file addresses
  localparam logic [11:0] FPOL_ADDR_CMD = 12'hff8;
  localparam logic [11:0] FPOL_ADDR_PAGE = 12'hff9;
  localparam logic [11:0] FPOL_ADDR_KHZ_HI = 12'hffa;
  localparam logic [11:0] FPOL_ADDR_KHZ_LO = 12'hffb;

  // flash commands
  localparam logic [7:0] FPOL_CMD_LOCK = 8'h00;
  localparam logic [7:0] FPOL_CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] FPOL_CMD_UNLOCK2 = 8'h8c;
  localparam logic [7:0] FPOL_CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] FPOL_CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] FPOL_CMD_SEL_PROTECT = 8'h5e;

  // flash state codes
  localparam logic [5:0] FPOL_ST_LOCKED = 6'h00;
  localparam logic [5:0] FPOL_ST_FIRST = 6'h01;
  localparam logic [5:0] FPOL_ST_SECOND = 6'h02;
  localparam logic [5:0] FPOL_ST_UNLOCKED = 6'h03;
  localparam logic [5:0] FPOL_ST_PROTECT = 6'h04;

  // reset values
  localparam logic [7:0] FPOL_RST_BYTE = 8'h00;
  localparam logic [7:0] FPOL_OPT_ERASED = 8'hff;
  localparam logic [15:0] FPOL_OPT_ADDR = 16'h0000;

  // option byte field positions
  localparam int FPOL_OPT_WATCHDOG_RESPONSE_SELECT = 7;
  localparam int FPOL_OPT_WATCHDOG_ALWAYS_ON = 6;
  localparam int FPOL_OPT_OSC_HI = 5;
  localparam int FPOL_OPT_OSC_LO = 4;
  localparam int FPOL_OPT_BO_AO = 3;
  localparam int FPOL_OPT_RD_LOCK = 2;
  localparam int FPOL_OPT_WR_LOCK = 0;

  // page number bits that name the sector
  localparam int FPOL_SECT_HI = 6;
  localparam int FPOL_SECT_LO = 4;

  typedef enum logic [4:0] {
    FC_LOCKED = 5'b00001,
    FC_FIRST = 5'b00010,
    FC_SECOND = 5'b00100,
    FC_UNLOCKED = 5'b01000,
    FC_PROTECT = 5'b10000
  } fpol_cmd_state_type;

  typedef enum logic [2:0] {
    FO_REQ = 3'b001,
    FO_WAIT = 3'b010,
    FO_IDLE = 3'b100
  } fpol_fetch_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } fpol_reg_req_type;

  typedef struct packed {
    logic wdt_short_reset;
    logic wdt_on_at_powerup;
    logic [1:0] osc_mode;
    logic brownout_in_stop;
    logic code_readable;
    logic user_write_ok;
  } fpol_opt_cfg_type;

  // raw option byte to configuration fields
  function automatic fpol_opt_cfg_type fpol_decode_opt(input logic [7:0] ob);
    fpol_opt_cfg_type c;
    c.wdt_short_reset = ob[FPOL_OPT_WATCHDOG_RESPONSE_SELECT];
    c.wdt_on_at_powerup = ~ob[FPOL_OPT_WATCHDOG_ALWAYS_ON];
    c.osc_mode = ob[FPOL_OPT_OSC_HI:FPOL_OPT_OSC_LO];
    c.brownout_in_stop = ob[FPOL_OPT_BO_AO];
    c.code_readable = ob[FPOL_OPT_RD_LOCK];
    c.user_write_ok = ob[FPOL_OPT_WR_LOCK];
    return c;
  endfunction

  function automatic logic [5:0] fpol_state_code(input fpol_cmd_state_type s);
    logic [5:0] code;
    code = FPOL_ST_LOCKED;
    case (s)
      FC_FIRST: code = FPOL_ST_FIRST;
      FC_SECOND: code = FPOL_ST_SECOND;
      FC_UNLOCKED: code = FPOL_ST_UNLOCKED;
      FC_PROTECT: code = FPOL_ST_PROTECT;
      default: code = FPOL_ST_LOCKED;
    endcase
    return code;
  endfunction

endpackage

// ### src/fpol_opt_fetch.sv
// reads the option byte from flash after each reset or reload request
`timescale 1ns/1ps
module fpol_opt_fetch
  import fpol_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  output logic done,
  output logic [7:0] opt_byte,
  // flash read port
  output logic flash_rd_req,
  output logic [15:0] flash_rd_addr,
  input wire logic flash_rd_valid,
  input wire logic [7:0] flash_rd_data
);

  fpol_fetch_state_type state_r;
  fpol_fetch_state_type state_nxt;
  logic done_r;
  logic req_r;
  logic [7:0] byte_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FO_REQ: state_nxt = FO_WAIT;
      FO_WAIT: if (flash_rd_valid) state_nxt = FO_IDLE;
      FO_IDLE: if (start) state_nxt = FO_REQ;
      default: state_nxt = FO_REQ;
    endcase
  end

  // reset itself starts a fetch
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= FO_REQ;
      done_r <= 1'b0;
      req_r <= 1'b0;
      byte_r <= FPOL_OPT_ERASED;
    end
    else
    begin
      state_r <= state_nxt;
      req_r <= (state_r == FO_REQ);
      done_r <= (state_r == FO_WAIT) && flash_rd_valid;
      if ((state_r == FO_WAIT) && flash_rd_valid)
      begin
        byte_r <= flash_rd_data;
      end
    end
  end

  assign done = done_r;
  assign opt_byte = byte_r;
  assign flash_rd_req = req_r;
  assign flash_rd_addr = FPOL_OPT_ADDR;

endmodule // fpol_opt_fetch

// ### verification/fpol_loader_tb_top.sv
// self-checking bench of the flash protect and option loader
`timescale 1ns/1ps
module fpol_loader_tb_top
  import fpol_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  fpol_reg_req_type reg_req = '0;
  logic dbg_mode = 1'b0;
  logic stop_recover = 1'b0;
  logic flash_rd_valid = 1'b0;
  logic [7:0] flash_rd_data = 8'h00;
  logic [6:0] prog_page = 7'h00;
  logic [7:0] reg_rdata;
  logic [7:0] sector_lock_mask;
  logic [7:0] page_select_reg;
  logic cpu_hold;
  logic flash_rd_req;
  logic prog_permit;
  logic [15:0] flash_rd_addr;
  logic [15:0] flash_clock_khz;
  logic [5:0] flash_state_reg;
  fpol_opt_cfg_type opt_cfg;
  fpol_opt_cfg_type cfg_exp;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  fpol_loader DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .dbg_mode(dbg_mode), .stop_recover(stop_recover), .cpu_hold(cpu_hold),
    .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
    .prog_page(prog_page), .prog_permit(prog_permit),
    .sector_lock_mask(sector_lock_mask), .page_select_reg(page_select_reg),
    .flash_clock_khz(flash_clock_khz), .flash_state_reg(flash_state_reg),
    .opt_cfg(opt_cfg)
  );

  always #50 ref_clk = ~ref_clk;

  // cut a hang short
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input fpol_opt_cfg_type got, input fpol_opt_cfg_type exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    reg_req = '0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    reg_req = '0;
    chk(16'(reg_rdata), 16'(exp));
  endtask

  // answer one option fetch with byte ob and judge the loaded fields
  task automatic load_opt(input logic [7:0] ob);
    int n;
    n = 0;
    while (flash_rd_req !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    chk(16'(flash_rd_req), 16'h0001);
    chk(flash_rd_addr, FPOL_OPT_ADDR);
    chk(16'(cpu_hold), 16'h0001);
    @(negedge ref_clk);
    flash_rd_valid = 1'b1;
    flash_rd_data = ob;
    @(negedge ref_clk);
    flash_rd_valid = 1'b0;
    flash_rd_data = ~ob;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 20)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    chk(16'(cpu_hold), 16'h0000);
    cfg_exp = '{ob[7], ~ob[6], ob[5:4], ob[3], ob[2], ob[0]};
    chk_cfg(opt_cfg, cfg_exp);
  endtask

  task automatic t_freq();
    wr(FPOL_ADDR_KHZ_HI, 8'h27);
    wr(FPOL_ADDR_KHZ_LO, 8'h10);
    chk(flash_clock_khz, 16'h2710);
    rd_chk(FPOL_ADDR_KHZ_HI, 8'h27);
    rd_chk(FPOL_ADDR_KHZ_LO, 8'h10);
    $display("test freq done");
  endtask

  task automatic t_page_sel();
    wr(FPOL_ADDR_CMD, FPOL_CMD_LOCK);
    wr(FPOL_ADDR_PAGE, 8'h25);
    chk(16'(page_select_reg), 16'h0025);
    chk(16'(sector_lock_mask), 16'h0000);
    rd_chk(FPOL_ADDR_PAGE, 8'h25);
    $display("test page select done");
  endtask

  task automatic t_protect();
    wr(FPOL_ADDR_CMD, FPOL_CMD_SEL_PROTECT);
    rd_chk(FPOL_ADDR_CMD, 8'h04);
    chk(16'(flash_state_reg), 16'(FPOL_ST_PROTECT));
    wr(FPOL_ADDR_PAGE, 8'h11);
    chk(16'(sector_lock_mask), 16'h0011);
    chk(16'(page_select_reg), 16'h0025);
    wr(FPOL_ADDR_PAGE, 8'h02);
    chk(16'(sector_lock_mask), 16'h0013);
    wr(FPOL_ADDR_PAGE, 8'h00);
    chk(16'(sector_lock_mask), 16'h0013);
    rd_chk(FPOL_ADDR_PAGE, 8'h13);
    $display("test protect done");
  endtask

  task automatic t_permit();
    wr(FPOL_ADDR_CMD, FPOL_CMD_LOCK);
    wr(FPOL_ADDR_CMD, FPOL_CMD_UNLOCK1);
    wr(FPOL_ADDR_CMD, FPOL_CMD_UNLOCK2);
    rd_chk(FPOL_ADDR_CMD, 8'h02);
    wr(FPOL_ADDR_PAGE, 8'h20);
    rd_chk(FPOL_ADDR_CMD, 8'h03);
    prog_page = 7'h20;
    @(negedge ref_clk);
    chk(16'(prog_permit), 16'h0001);
    prog_page = 7'h10;
    @(negedge ref_clk);
    chk(16'(prog_permit), 16'h0000);
    $display("test permit done");
  endtask

  task automatic t_debug();
    dbg_mode = 1'b1;
    wr(FPOL_ADDR_CMD, FPOL_CMD_LOCK);
    wr(FPOL_ADDR_CMD, FPOL_CMD_SEL_PROTECT);
    wr(FPOL_ADDR_PAGE, 8'h01);
    chk(16'(sector_lock_mask), 16'h0001);
    dbg_mode = 1'b0;
    wr(FPOL_ADDR_CMD, FPOL_CMD_LOCK);
    wr(FPOL_ADDR_CMD, FPOL_CMD_SEL_PROTECT);
    wr(FPOL_ADDR_PAGE, 8'h00);
    chk(16'(sector_lock_mask), 16'h0001);
    $display("test debug done");
  endtask

  task automatic t_bad_cmd();
    wr(FPOL_ADDR_CMD, FPOL_CMD_LOCK);
    wr(FPOL_ADDR_CMD, FPOL_CMD_UNLOCK1);
    rd_chk(FPOL_ADDR_CMD, 8'h01);
    wr(FPOL_ADDR_CMD, 8'h42);
    rd_chk(FPOL_ADDR_CMD, 8'h00);
    wr(FPOL_ADDR_CMD, FPOL_CMD_UNLOCK1);
    wr(FPOL_ADDR_CMD, FPOL_CMD_SEL_PROTECT);
    chk(16'(flash_state_reg), 16'(FPOL_ST_LOCKED));
    $display("test bad command done");
  endtask

  task automatic t_unmapped();
    wr(12'h000, 8'h55);
    rd_chk(12'h000, 8'h00);
    chk_cfg(opt_cfg, cfg_exp);
    $display("test unmapped done");
  endtask

  // reload through stop recovery with every oscillator code
  task automatic t_reload();
    logic [7:0] tbl [4];
    tbl = '{8'h02, 8'h96, 8'h6b, 8'hff};
    prog_page = 7'h20;
    foreach (tbl[i])
    begin
      @(negedge ref_clk);
      stop_recover = 1'b1;
      @(negedge ref_clk);
      stop_recover = 1'b0;
      chk_cfg(opt_cfg, cfg_exp);
      load_opt(tbl[i]);
      @(negedge ref_clk);
      chk(16'(prog_permit), 16'(tbl[i][0]));
    end
    $display("test reload done");
  endtask

  initial
  begin
    repeat (6) @(negedge ref_clk);
    chk(16'(cpu_hold), 16'h0001);
    chk(16'(sector_lock_mask), 16'h0000);
    chk(flash_clock_khz, 16'h0000);
    chk(16'(prog_permit), 16'h0000);
    sys_rst = 1'b0;
    load_opt(FPOL_OPT_ERASED);
    $display("test reset done");
    t_freq();
    t_page_sel();
    t_protect();
    t_permit();
    t_debug();
    t_bad_cmd();
    t_unmapped();
    t_reload();
    report_and_stop();
  end
endmodule // fpol_loader_tb_top
